// ---- verilog/config_boot_sequencer.sv ----
// Operation
// - Reset release: drive init and done low
// - During power-on reset all pins high-impedance
// - Init clears memory, waits time, request, init
// - Init pin driven while clearing, sampled as input
// - Init released high moves to configuration
// - Signature read in bounded loop, then preamble
// - Bit twelve clear: read command, vendor word
// - Bit twelve set: discoverable-parameters read, code
// - Three consecutive matches set signature flag
// - Loop timeout goes on with flag clear
// - Flag set skips signature on warm boots
// - Preamble timeout declares boot failure
// - Keep fetching data until configuration ends
// - Init high while clean, low on error
// - Pins tri-stated until configured, then user
// - Persist bits keep configuration ports in user
// - Scan port persistence follows its enable pin
// - On error: init low, done low, no wake
// - Start slow clock, switch after accepted frequency
`timescale 1ns/100ps
module config_boot_sequencer #(
  parameter logic [19:0] SIG_LIMIT = 20'(boot_pkg::SIG_LIMIT_SCK),
  parameter logic [19:0] PRE_LIMIT = 20'(boot_pkg::PRE_LIMIT_SCK)
) (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        programRequestN,
  input  wire logic                        reconfigureCommand,
  input  wire logic                        controlRegisterOneSfdp,
  input  wire logic [23:0]                 bootAddress,
  input  wire boot_pkg::keep_config_pins_t keepConfigPins,
  input  wire logic                        jtagEnable,
  input  wire logic                        initStatusIn,
  output logic                             initStatusOut,
  output logic                             initStatusOeN,
  input  wire logic                        doneIn,
  output logic                             doneOut,
  output logic                             doneOeN,
  output logic                             controllerClock,
  output logic                             controllerClockInverted,
  output logic                             controllerChipSelectN,
  output logic                             controllerDataOut0,
  input  wire logic                        controllerDataIn1,
  output logic                             flashOeN,
  input  wire logic                        freqAccept,
  input  wire logic [7:0]                  freqHalfPeriod,
  output logic [7:0]                       cfgData,
  output logic                             cfgValid,
  input  wire logic                        cfgReady,
  input  wire logic                        cfgError,
  input  wire logic                        cfgEnd,
  output logic                             gpioUserState,
  output logic [7:0]                       keepControllerPins,
  output logic [7:0]                       keepTargetPins,
  output logic                             keepJtagPins,
  output logic                             signatureOk,
  output logic                             bootFailed,
  output boot_pkg::boot_state_t            bootState
);
  logic [4:0]            asyncIn;
  logic [4:0]            sync1_reg;
  logic [4:0]            sync2_reg;
  logic                  progSync;
  logic                  initSync;
  logic                  doneSync;
  logic                  misoSync;
  logic                  jtagSync;
  logic                  progPrev_reg;
  logic                  warmBoot;
  boot_pkg::boot_state_t state_reg;
  boot_pkg::boot_state_t state_next;
  logic [11:0]           clearCnt_reg;
  logic [11:0]           clearCnt_next;
  logic [19:0]           sigTimer_reg;
  logic [19:0]           preTimer_reg;
  logic [1:0]            matchCnt_reg;
  logic [1:0]            byteCnt_reg;
  logic [31:0]           word_reg;
  logic [31:0]           window_reg;
  logic [31:0]           wordNow;
  logic [31:0]           windowNow;
  logic                  sigMatch;
  logic                  wordDone;
  logic                  sigTimeout;
  logic                  preTimeout;
  logic [7:0]            halfPeriod_reg;
  boot_pkg::flash_req_t  req;
  logic                  readerStart;
  logic                  readerStop;
  logic                  readerBusy;
  logic                  readerHold;
  logic [7:0]            rxByte;
  logic                  rxValid;
  logic                  sckRise;
  logic                  fifoInValid;
  logic                  fifoInReady;
  logic                  fifoOutValid;
  logic                  fifoOutReady;
  logic [7:0]            fifoOutData;

  function automatic logic isReading(input boot_pkg::boot_state_t s);
    return s == boot_pkg::ST_SIG_READ || s == boot_pkg::ST_PRE_READ
           || s == boot_pkg::ST_LOAD;
  endfunction

  function automatic logic [7:0] keepMask(input boot_pkg::port_keep_t k,
                                          input logic hasInverted);
    logic [7:0] m;
    m = 8'h00;
    if (k.enable)
    begin
      m[boot_pkg::PIN_CLK] = 1'b1;
      m[boot_pkg::PIN_CS] = 1'b1;
      m[boot_pkg::PIN_D0] = 1'b1;
      m[boot_pkg::PIN_D1] = 1'b1;
      if (k.width == boot_pkg::PORT_QUAD || k.width == boot_pkg::PORT_OCTAL)
        m[boot_pkg::PIN_D23] = 1'b1;
      if (k.width == boot_pkg::PORT_OCTAL)
      begin
        m[boot_pkg::PIN_D47] = 1'b1;
        m[boot_pkg::PIN_DS] = 1'b1;
        m[boot_pkg::PIN_CLKN] = hasInverted;
      end
    end
    return m;
  endfunction

  // Pin inputs cross into the clock domain
  assign asyncIn = {jtagEnable, controllerDataIn1, doneIn, initStatusIn, programRequestN};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : gen_sync
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_reg[gi] <= boot_pkg::SYNC_RESET[gi];
          sync2_reg[gi] <= boot_pkg::SYNC_RESET[gi];
        end
        else
        begin
          sync1_reg[gi] <= asyncIn[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign progSync = sync2_reg[0];
  assign initSync = sync2_reg[1];
  assign doneSync = sync2_reg[2];
  assign misoSync = sync2_reg[3];
  assign jtagSync = sync2_reg[4];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      progPrev_reg <= 1'b1;
    else
      progPrev_reg <= progSync;
  end

  assign warmBoot = ((progPrev_reg && !progSync) || reconfigureCommand)
                    && state_reg != boot_pkg::ST_POR && state_reg != boot_pkg::ST_INIT;

  // Read assembly and comparison
  assign wordNow = {rxByte, word_reg[31:24], word_reg[23:16], word_reg[15:8]};
  assign windowNow = {window_reg[23:0], rxByte};
  assign sigMatch = wordNow == (controlRegisterOneSfdp ? boot_pkg::SFDP_CODE
                                                       : boot_pkg::VENDOR_SIG);
  assign wordDone = rxValid && byteCnt_reg == boot_pkg::SIG_BYTES;
  assign sigTimeout = sigTimer_reg >= SIG_LIMIT;
  assign preTimeout = preTimer_reg >= PRE_LIMIT;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      boot_pkg::ST_POR:
        state_next = boot_pkg::ST_INIT;
      boot_pkg::ST_INIT:
        if (clearCnt_reg == 12'h000 && progSync && initSync && initStatusOeN)
          state_next = signatureOk ? boot_pkg::ST_PRE_START
                                   : boot_pkg::ST_SIG_START;
      boot_pkg::ST_SIG_START:
        if (sigTimeout)
          state_next = boot_pkg::ST_PRE_START;
        else if (!readerBusy)
          state_next = boot_pkg::ST_SIG_READ;
      boot_pkg::ST_SIG_READ:
        if (sigTimeout)
          state_next = boot_pkg::ST_PRE_START;
        else if (wordDone)
          state_next = (sigMatch && matchCnt_reg == boot_pkg::SIG_MATCHES - 2'h1)
                       ? boot_pkg::ST_PRE_START : boot_pkg::ST_SIG_START;
      boot_pkg::ST_PRE_START:
        if (!readerBusy)
          state_next = boot_pkg::ST_PRE_READ;
      boot_pkg::ST_PRE_READ:
        if (preTimeout)
          state_next = boot_pkg::ST_FAIL;
        else if (rxValid && windowNow == boot_pkg::PREAMBLE)
          state_next = boot_pkg::ST_LOAD;
      boot_pkg::ST_LOAD:
        if (cfgError)
          state_next = boot_pkg::ST_FAIL;
        else if (cfgEnd)
          state_next = boot_pkg::ST_DONE;
      boot_pkg::ST_DONE:
        state_next = boot_pkg::ST_DONE;
      boot_pkg::ST_FAIL:
        state_next = boot_pkg::ST_FAIL;
      default:
        state_next = boot_pkg::ST_POR;
    endcase
    if (warmBoot)
      state_next = boot_pkg::ST_INIT;
  end

  always_comb
  begin
    clearCnt_next = clearCnt_reg;
    if (state_next == boot_pkg::ST_INIT && state_reg != boot_pkg::ST_INIT)
      clearCnt_next = boot_pkg::INIT_CLEAR_CYC;
    else if (state_reg == boot_pkg::ST_INIT && clearCnt_reg != 12'h000)
      clearCnt_next = clearCnt_reg - 12'h001;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= boot_pkg::ST_POR;
      clearCnt_reg <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      clearCnt_reg <= clearCnt_next;
    end
  end

  // Signature loop bookkeeping
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sigTimer_reg <= 20'h0_0000;
      matchCnt_reg <= 2'h0;
      byteCnt_reg <= 2'h0;
      word_reg <= 32'h0000_0000;
      signatureOk <= 1'b0;
    end
    else
    begin
      if (state_reg == boot_pkg::ST_INIT)
      begin
        sigTimer_reg <= 20'h0_0000;
        matchCnt_reg <= 2'h0;
      end
      else if (sckRise && (state_reg == boot_pkg::ST_SIG_START
                           || state_reg == boot_pkg::ST_SIG_READ)
               && !sigTimeout)
        sigTimer_reg <= sigTimer_reg + 20'h0_0001;
      if (state_reg == boot_pkg::ST_SIG_START)
        byteCnt_reg <= 2'h0;
      else if (rxValid && state_reg == boot_pkg::ST_SIG_READ)
      begin
        byteCnt_reg <= byteCnt_reg + 2'h1;
        word_reg <= wordNow;
        if (wordDone)
        begin
          matchCnt_reg <= sigMatch ? matchCnt_reg + 2'h1 : 2'h0;
          if (sigMatch && matchCnt_reg == boot_pkg::SIG_MATCHES - 2'h1)
            signatureOk <= 1'b1;
        end
      end
    end
  end

  // Preamble search
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      preTimer_reg <= 20'h0_0000;
      window_reg <= 32'h0000_0000;
    end
    else if (state_reg == boot_pkg::ST_PRE_START)
    begin
      preTimer_reg <= 20'h0_0000;
      window_reg <= 32'h0000_0000;
    end
    else if (state_reg == boot_pkg::ST_PRE_READ)
    begin
      if (sckRise && !preTimeout)
        preTimer_reg <= preTimer_reg + 20'h0_0001;
      if (rxValid)
        window_reg <= windowNow;
    end
  end

  // Flash clock rate
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      halfPeriod_reg <= boot_pkg::SLOW_HALF;
    else if (state_reg == boot_pkg::ST_INIT)
      halfPeriod_reg <= boot_pkg::SLOW_HALF;
    else if (freqAccept && state_reg == boot_pkg::ST_LOAD)
      halfPeriod_reg <= (freqHalfPeriod == 8'h00) ? 8'h01 : freqHalfPeriod;
  end

  always_comb
  begin
    req.cmd = boot_pkg::CMD_READ;
    req.addr = bootAddress;
    req.dummy = 1'b0;
    if (state_reg == boot_pkg::ST_SIG_START && controlRegisterOneSfdp)
    begin
      req.cmd = boot_pkg::CMD_SFDP;
      req.addr = boot_pkg::SFDP_ADDR;
      req.dummy = 1'b1;
    end
  end

  assign readerStart = !readerBusy && (state_reg == boot_pkg::ST_SIG_START
                                       || state_reg == boot_pkg::ST_PRE_START);
  assign readerStop = readerBusy && !isReading(state_next);
  assign readerHold = (state_reg == boot_pkg::ST_LOAD) && !fifoInReady;

  spi_flash_reader u_reader (
    .clock      (clock),
    .nrst       (nrst),
    .halfPeriod (halfPeriod_reg),
    .start      (readerStart),
    .req        (req),
    .stop       (readerStop),
    .hold       (readerHold),
    .misoSync   (misoSync),
    .sck        (controllerClock),
    .sckN       (controllerClockInverted),
    .csN        (controllerChipSelectN),
    .mosi       (controllerDataOut0),
    .rxByte     (rxByte),
    .rxValid    (rxValid),
    .sckRise    (sckRise),
    .busy       (readerBusy)
  );

  assign fifoInValid = rxValid && state_reg == boot_pkg::ST_LOAD;
  assign fifoOutReady = !cfgValid || cfgReady;

  boot_fifo #(
    .WIDTH (boot_pkg::FIFO_WIDTH),
    .DEPTH (boot_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .flush    (state_reg == boot_pkg::ST_INIT),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (rxByte),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Output stage towards configuration memory
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cfgValid <= 1'b0;
      cfgData <= 8'h00;
    end
    else if (state_reg == boot_pkg::ST_INIT)
      cfgValid <= 1'b0;
    else if (fifoOutReady)
    begin
      cfgValid <= fifoOutValid;
      if (fifoOutValid)
        cfgData <= fifoOutData;
    end
  end

  // Status pins: both open-drain, only ever pulled low
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      initStatusOut <= 1'b0;
      doneOut <= 1'b0;
      initStatusOeN <= 1'b1;
      doneOeN <= 1'b1;
      flashOeN <= 1'b1;
      bootFailed <= 1'b0;
    end
    else
    begin
      initStatusOut <= 1'b0;
      doneOut <= 1'b0;
      initStatusOeN <= !(state_next == boot_pkg::ST_FAIL
                         || (state_next == boot_pkg::ST_INIT
                             && clearCnt_next != 12'h000));
      doneOeN <= state_next == boot_pkg::ST_DONE;
      flashOeN <= !(isReading(state_next)
                    || state_next == boot_pkg::ST_SIG_START
                    || state_next == boot_pkg::ST_PRE_START
                    || (state_next == boot_pkg::ST_DONE
                        && keepConfigPins.controller.enable));
      bootFailed <= state_next == boot_pkg::ST_FAIL;
    end
  end

  // User-mode pin handover
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      gpioUserState <= 1'b0;
      keepControllerPins <= 8'h00;
      keepTargetPins <= 8'h00;
      keepJtagPins <= 1'b0;
    end
    else if (state_next != boot_pkg::ST_DONE)
    begin
      gpioUserState <= 1'b0;
      keepControllerPins <= 8'h00;
      keepTargetPins <= 8'h00;
      keepJtagPins <= 1'b0;
    end
    else if (doneSync)
    begin
      gpioUserState <= 1'b1;
      keepControllerPins <= keepMask(keepConfigPins.controller, 1'b1);
      keepTargetPins <= keepMask(keepConfigPins.target, 1'b0);
      keepJtagPins <= jtagSync;
    end
  end

  assign bootState = state_reg;
endmodule

// ---- verilog/boot_pkg.sv ----
package boot_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SLOW_SPI_HZ = 3_500_000;
  localparam logic [7:0] SLOW_HALF = 8'((CLK_HZ + 2 * SLOW_SPI_HZ - 1) / (2 * SLOW_SPI_HZ));
  localparam int SIG_LIMIT_SCK = 600_000;
  localparam int PRE_LIMIT_SCK = 600_000;
  localparam int INIT_CLEAR_US = 100;
  localparam logic [11:0] INIT_CLEAR_CYC = 12'(INIT_CLEAR_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_SFDP = 8'h5A;
  localparam logic [31:0] SFDP_CODE = 32'h5044_4653;
  // Arbitrary value, stands in for the maker's signature word
  localparam logic [31:0] VENDOR_SIG = 32'h1234_5678;
  localparam logic [31:0] PREAMBLE = 32'hA5C3_3CA5;
  localparam logic [23:0] SFDP_ADDR = 24'h00_0000;
  localparam logic [1:0] SIG_MATCHES = 2'h3;
  localparam logic [1:0] SIG_BYTES = 2'h3;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [5:0] HDR_BITS_DUMMY = 6'h28;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] SYNC_RESET = 5'h07;
  localparam int PIN_CLK = 0;
  localparam int PIN_CLKN = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_D0 = 3;
  localparam int PIN_D1 = 4;
  localparam int PIN_D23 = 5;
  localparam int PIN_D47 = 6;
  localparam int PIN_DS = 7;

  typedef enum logic [1:0] {
    PORT_SERIAL = 2'b00,
    PORT_DUAL   = 2'b01,
    PORT_QUAD   = 2'b10,
    PORT_OCTAL  = 2'b11
  } port_width_t;

  typedef struct packed {
    logic        enable;
    port_width_t width;
  } port_keep_t;

  typedef struct packed {
    port_keep_t controller;
    port_keep_t target;
  } keep_config_pins_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic        dummy;
  } flash_req_t;

  typedef enum logic [3:0] {
    ST_POR       = 4'b0000,
    ST_INIT      = 4'b0001,
    ST_SIG_START = 4'b0010,
    ST_SIG_READ  = 4'b0011,
    ST_PRE_START = 4'b0100,
    ST_PRE_READ  = 4'b0101,
    ST_LOAD      = 4'b0110,
    ST_DONE      = 4'b0111,
    ST_FAIL      = 4'b1000
  } boot_state_t;
endpackage

// ---- verilog/boot_fifo.sv ----
`timescale 1ns/100ps
module boot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;

  assign inReady = (wrPtr_reg - rdPtr_reg) != (AW + 1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clock)
  begin
    if (inValid && inReady)
      mem[wrPtr_reg[AW-1:0]] <= inData;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else if (flush)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else
    begin
      if (inValid && inReady)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (outValid && outReady)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// ---- verilog/spi_flash_reader.sv ----
`timescale 1ns/100ps
module spi_flash_reader (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [7:0]             halfPeriod,
  input  wire logic                   start,
  input  wire boot_pkg::flash_req_t   req,
  input  wire logic                   stop,
  input  wire logic                   hold,
  input  wire logic                   misoSync,
  output logic                        sck,
  output logic                        sckN,
  output logic                        csN,
  output logic                        mosi,
  output logic [7:0]                  rxByte,
  output logic                        rxValid,
  output logic                        sckRise,
  output logic                        busy
);
  logic [7:0]  divCnt_reg;
  logic [39:0] hdr_reg;
  logic [5:0]  bitCnt_reg;
  logic [5:0]  hdrLen_reg;
  logic [2:0]  rxBits_reg;
  logic [7:0]  rxShift_reg;
  logic        tick;
  logic        rise;
  logic        fall;

  assign tick = busy && (divCnt_reg >= halfPeriod - 8'h01);
  assign rise = tick && !sck && !hold;
  assign fall = tick && sck;

  // Mode 0 shifting: drive on falling edge, sample on rising edge
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      csN <= 1'b1;
      sck <= 1'b0;
      sckN <= 1'b1;
      mosi <= 1'b0;
      divCnt_reg <= 8'h00;
      hdr_reg <= 40'h00_0000_0000;
      bitCnt_reg <= 6'h00;
      hdrLen_reg <= 6'h00;
    end
    else if (start)
    begin
      busy <= 1'b1;
      csN <= 1'b0;
      sck <= 1'b0;
      sckN <= 1'b1;
      mosi <= req.cmd[7];
      divCnt_reg <= 8'h00;
      hdr_reg <= {req.cmd, req.addr, 8'h00};
      bitCnt_reg <= 6'h00;
      hdrLen_reg <= req.dummy ? boot_pkg::HDR_BITS_DUMMY : boot_pkg::HDR_BITS;
    end
    else if (stop)
    begin
      busy <= 1'b0;
      csN <= 1'b1;
      sck <= 1'b0;
      sckN <= 1'b1;
    end
    else if (busy)
    begin
      if (rise || fall)
        divCnt_reg <= 8'h00;
      else if (!tick)
        divCnt_reg <= divCnt_reg + 8'h01;
      if (rise)
      begin
        sck <= 1'b1;
        sckN <= 1'b0;
        if (bitCnt_reg < hdrLen_reg)
          bitCnt_reg <= bitCnt_reg + 6'h01;
      end
      if (fall)
      begin
        sck <= 1'b0;
        sckN <= 1'b1;
        hdr_reg <= {hdr_reg[38:0], 1'b0};
        mosi <= hdr_reg[38];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rxBits_reg <= 3'h0;
      rxShift_reg <= 8'h00;
      rxByte <= 8'h00;
      rxValid <= 1'b0;
      sckRise <= 1'b0;
    end
    else
    begin
      rxValid <= 1'b0;
      sckRise <= rise;
      if (start)
        rxBits_reg <= 3'h0;
      else if (rise && bitCnt_reg >= hdrLen_reg)
      begin
        rxShift_reg <= {rxShift_reg[6:0], misoSync};
        rxBits_reg <= rxBits_reg + 3'h1;
        if (rxBits_reg == 3'h7)
        begin
          rxByte <= {rxShift_reg[6:0], misoSync};
          rxValid <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- tb/config_boot_sequencer_checker.sv ----
`timescale 1ns/100ps
module config_boot_sequencer_checker (
  input wire logic                  clock,
  input wire logic                  nrst,
  input wire logic                  initStatusIn,
  input wire logic                  initStatusOeN,
  input wire logic                  doneOeN,
  input wire logic                  flashOeN,
  input wire logic                  controllerClock,
  input wire logic                  controllerChipSelectN,
  input wire logic [7:0]            cfgData,
  input wire logic                  cfgValid,
  input wire logic                  cfgReady,
  input wire logic                  cfgError,
  input wire logic                  cfgEnd,
  input wire logic                  bootFailed,
  input wire logic                  signatureOk,
  input wire boot_pkg::boot_state_t bootState
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_held;
    (bootState == boot_pkg::ST_INIT && !initStatusIn) [*3];
  endsequence
  property p_exit;
    bootState == boot_pkg::ST_POR |=> bootState == boot_pkg::ST_INIT && !initStatusOeN && !doneOeN;
  endproperty
  a_exit: assert property (p_exit) else $error("reset exit");
  property p_hiz;
    bootState inside {boot_pkg::ST_POR, boot_pkg::ST_INIT} |-> flashOeN;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins driven");
  property p_hold;
    s_held |=> bootState == boot_pkg::ST_INIT;
  endproperty
  a_hold: assert property (p_hold) else $error("left init");
  property p_fail;
    bootState == boot_pkg::ST_FAIL |-> !initStatusOeN && !doneOeN && bootFailed;
  endproperty
  a_fail: assert property (p_fail) else $error("fail pins");
  property p_err;
    bootState == boot_pkg::ST_LOAD && cfgError |=> bootState == boot_pkg::ST_FAIL;
  endproperty
  a_err: assert property (p_err) else $error("error ignored");
  property p_end;
    bootState == boot_pkg::ST_LOAD && cfgEnd && !cfgError |=> doneOeN;
  endproperty
  a_end: assert property (p_end) else $error("end ignored");
  property p_stall;
    cfgValid && !cfgReady |=> cfgValid && $stable(cfgData);
  endproperty
  a_stall: assert property (p_stall) else $error("stream moved");
  property p_idle;
    controllerChipSelectN |-> !controllerClock;
  endproperty
  a_idle: assert property (p_idle) else $error("clock while idle");
  property p_skip;
    $past(signatureOk, 2) |-> !(bootState inside {boot_pkg::ST_SIG_START, boot_pkg::ST_SIG_READ});
  endproperty
  a_skip: assert property (p_skip) else $error("signature repeated");
endmodule
bind config_boot_sequencer config_boot_sequencer_checker chk_u (.*);

// ---- tb/spi_flash_model.sv ----
`timescale 1ns/100ps
module spi_flash_model (
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic mosi,
  input  wire logic bad,
  output logic      miso,
  output logic [7:0] cmdSeen
);
  logic [7:0]  mem [16] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h78,
                            8'h56, 8'h34, 8'h12, 8'hA5, 8'hC3, 8'h3C, 8'hA5};
  logic [31:0] hdr = 32'h0000_0000;
  int          n = 0;
  int          k;
  initial
  begin
    miso = 1'b0;
    cmdSeen = 8'h00;
  end
  always @(negedge csN)
    n = 0;
  always @(posedge sck)
    if (!csN)
    begin
      hdr = (n < 32) ? {hdr[30:0], mosi} : hdr;
      n = n + 1;
      cmdSeen <= (n == 32) ? hdr[31:24] : cmdSeen;
    end
  // Released line shows the inverse of its last level
  always @(negedge sck or posedge csN)
    if (csN)
      miso <= ~miso;
    else if (n >= 32)
    begin
      k = n - 32;
      miso <= bad ? k[0] : mem[4'(hdr[3:0] + 8 + k / 8)][7 - k % 8];
    end
endmodule

// ---- tb/config_boot_sequencer_tb.sv ----
`timescale 1ns/100ps
module config_boot_sequencer_tb;
  logic clock = 1'b0;
  logic nrst, programRequestN, reconfigureCommand, controlRegisterOneSfdp, extInit, bad;
  logic freqAccept, cfgReady, cfgError, cfgEnd, controllerDataIn1, cfgValid, bootFailed;
  logic initStatusOeN, doneOeN, controllerClock, controllerChipSelectN, controllerDataOut0;
  logic flashOeN, gpioUserState, signatureOk, keepJtagPins;
  logic sfdpSeen = 1'b0;
  logic [7:0] cfgData, cmdSeen;
  boot_pkg::boot_state_t bootState;
  wire initStatusIn = initStatusOeN & extInit;
  int error_cnt = 0;
  int comparisons = 0;
  config_boot_sequencer #(.SIG_LIMIT(20'h0_0190), .PRE_LIMIT(20'h0_0190)) dut_u (.clock, .nrst,
    .programRequestN, .reconfigureCommand, .controlRegisterOneSfdp, .bootAddress(24'h00_0000),
    .keepConfigPins('0), .jtagEnable(extInit), .initStatusIn, .initStatusOut(), .initStatusOeN,
    .doneIn(doneOeN), .doneOut(), .doneOeN, .controllerClock, .controllerClockInverted(),
    .controllerChipSelectN, .controllerDataOut0, .controllerDataIn1, .flashOeN, .freqAccept,
    .freqHalfPeriod(8'h04), .cfgData, .cfgValid, .cfgReady, .cfgError, .cfgEnd, .gpioUserState,
    .keepControllerPins(), .keepTargetPins(), .keepJtagPins, .signatureOk, .bootFailed,
    .bootState);
  spi_flash_model flash_u (.sck(controllerClock), .csN(controllerChipSelectN),
    .mosi(controllerDataOut0), .bad, .miso(controllerDataIn1), .cmdSeen);
  always #25 clock = ~clock;
  always @(posedge clock)
    sfdpSeen <= sfdpSeen | (cmdSeen === 8'h5A);
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic await(input boot_pkg::boot_state_t s);
    for (int i = 0; i < 20000 && bootState !== s; i++)
      cyc(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  initial
  begin
    #3_000_000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    {nrst, reconfigureCommand, controlRegisterOneSfdp, extInit, bad} = '0;
    {freqAccept, cfgReady, cfgError, cfgEnd} = '0;
    programRequestN = 1'b1;
    cyc(12);
    chk({initStatusOeN, doneOeN, flashOeN}, 32'h0000_0007);
    nrst = 1'b1;
    cyc(2);
    chk({bootState, initStatusOeN, doneOeN}, {boot_pkg::ST_INIT, 2'b00});
    cyc(2100);
    chk(bootState, boot_pkg::ST_INIT);
    extInit = 1'b1;
    await(boot_pkg::ST_LOAD);
    chk({signatureOk, cmdSeen}, 32'h0000_0103);
    pulse(freqAccept);
    cyc(400);
    chk(cfgValid, 1'b1);
    cfgReady = 1'b1;
    for (int k = 1; k < 5; k++)
    begin
      chk(cfgData, 8'(k * 17));
      cyc(1);
    end
    pulse(cfgEnd);
    chk({bootState, doneOeN}, {boot_pkg::ST_DONE, 1'b1});
    cyc(4);
    chk({gpioUserState, keepJtagPins}, 2'b11);
    pulse(reconfigureCommand);
    await(boot_pkg::ST_LOAD);
    chk(signatureOk, 1'b1);
    pulse(cfgError);
    chk({bootState, initStatusOeN, bootFailed}, {boot_pkg::ST_FAIL, 2'b01});
    programRequestN = 1'b0;
    cyc(2100);
    chk(bootState, boot_pkg::ST_INIT);
    programRequestN = 1'b1;
    nrst = 1'b0;
    controlRegisterOneSfdp = 1'b1;
    bad = 1'b1;
    cyc(2);
    nrst = 1'b1;
    await(boot_pkg::ST_FAIL);
    chk({signatureOk, bootFailed, sfdpSeen}, 32'h0000_0003);
    tally_and_finish;
  end
endmodule
